/* File: hw/dsm_channel_monitor.sv */
// Purpose: per-direction DS0 channel monitor and robbed-bit control on rx serial
// Assumes: framer gives per-bit strobes with channel and bit index, same clock
// Notes:   tx signaling bits are inserted on the line by logic outside this block
`timescale 1ns/1ns
module dsm_channel_monitor
    import dsm_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire dsm_cpu_req_t cpu_req,
    output logic [7:0]        cpu_rdata,
    input  wire logic         tx_bit_valid,
    input  wire dsm_bit_t     tx_bit,
    input  wire logic         rx_bit_valid,
    input  wire dsm_bit_t     rx_bit,
    output logic              rx_serial_data_out,
    output logic              rx_serial_valid
);

    // ***************************************************
    // registers
    // ***************************************************
    logic [7:0] tx_channel_select_control_reg;
    logic [7:0] rx_channel_select_control_reg;
    logic [7:0] sig_ctrl_reg;
    logic [7:0] tx_channel_monitor_reg;
    logic [7:0] rx_channel_monitor_reg;
    logic [7:0] tx_shift_reg;
    logic [7:0] rx_shift_reg;
    logic [7:0] cpu_rdata_next;
    logic [7:0] rx_sig_reg [DSM_SIG_COUNT];
    logic [7:0] tx_sig_reg [DSM_SIG_COUNT];
    logic [1:0] sig_letter_reg;
    logic       rob_seen_reg;
    logic       rx_chan_ok;
    logic       signaling_pass_through_bit;

    assign signaling_pass_through_bit = sig_ctrl_reg[DSM_SIG_PASS_BIT];
    assign rx_chan_ok = (rx_bit.channel >= DSM_FIRST_CH) && (rx_bit.channel <= DSM_LAST_CH);

    function automatic logic chan_hit(input dsm_bit_t b, input logic [7:0] sel);
        chan_hit = (b.channel == sel[DSM_SEL_MSB:0]);
    endfunction : chan_hit

    function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b);
        shift_in = {s[6:0], b};
    endfunction : shift_in

    function automatic logic is_sig_addr(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] off;
        off         = a - base;
        is_sig_addr = (a >= base) && (off < DSM_SIG_COUNT);
    endfunction : is_sig_addr

    function automatic logic [3:0] sig_index(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] off;
        off       = a - base;
        sig_index = off[3:0];
    endfunction : sig_index

    // three registers per signaling letter, eight channels per register
    function automatic logic [3:0] rx_sig_slot(input logic [1:0] letter, input logic [4:0] ch);
        logic [4:0] ch0;
        ch0         = ch - DSM_FIRST_CH;
        rx_sig_slot = ({2'h0, letter} * 4'h3) + {2'h0, ch0[4:3]};
    endfunction : rx_sig_slot

    function automatic logic [2:0] rx_sig_bit(input logic [4:0] ch);
        logic [4:0] ch0;
        ch0        = ch - DSM_FIRST_CH;
        rx_sig_bit = ch0[2:0];
    endfunction : rx_sig_bit

    // ***************************************************
    // cpu writes
    // ***************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_channel_select_control_reg <= DSM_TX_SEL_RESET;
            rx_channel_select_control_reg <= DSM_RX_SEL_RESET;
            sig_ctrl_reg                  <= DSM_SIG_CTRL_RESET;
        end else if (cpu_req.wr) begin
            case (cpu_req.addr)
                DSM_TX_SEL_OFFS: begin
                    tx_channel_select_control_reg <= cpu_req.wdata;
                end
                DSM_RX_SEL_OFFS: begin
                    // unassigned bits kept at zero regardless of host
                    rx_channel_select_control_reg <= cpu_req.wdata & DSM_RX_SEL_WMASK;
                end
                DSM_SIG_CTRL_OFFS: begin
                    sig_ctrl_reg <= cpu_req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // ***************************************************
    // cpu reads, no side effects
    // ***************************************************
    always_comb begin
        cpu_rdata_next = 8'h00;
        if (is_sig_addr(cpu_req.addr, DSM_RX_SIG_BASE)) begin
            cpu_rdata_next = rx_sig_reg[sig_index(cpu_req.addr, DSM_RX_SIG_BASE)];
        end else if (is_sig_addr(cpu_req.addr, DSM_TX_SIG_BASE)) begin
            cpu_rdata_next = tx_sig_reg[sig_index(cpu_req.addr, DSM_TX_SIG_BASE)];
        end else begin
            case (cpu_req.addr)
                DSM_TX_SEL_OFFS:   cpu_rdata_next = tx_channel_select_control_reg;
                DSM_TX_MON_OFFS:   cpu_rdata_next = tx_channel_monitor_reg;
                DSM_RX_SEL_OFFS:   cpu_rdata_next = rx_channel_select_control_reg;
                DSM_RX_MON_OFFS:   cpu_rdata_next = rx_channel_monitor_reg;
                DSM_SIG_CTRL_OFFS: cpu_rdata_next = sig_ctrl_reg;
                default:           cpu_rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_req.rd) begin
            cpu_rdata <= cpu_rdata_next;
        end
    end

    // ***************************************************
    // transmit monitor
    // ***************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_shift_reg           <= DSM_MON_RESET;
            tx_channel_monitor_reg <= DSM_MON_RESET;
        end else if (tx_bit_valid && chan_hit(tx_bit, tx_channel_select_control_reg)) begin
            tx_shift_reg <= shift_in(tx_shift_reg, tx_bit.bit_val);
            if (tx_bit.bit_idx == DSM_LAST_BIT) begin
                tx_channel_monitor_reg <= shift_in(tx_shift_reg, tx_bit.bit_val);
            end
        end
    end

    // ***************************************************
    // receive monitor
    // ***************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_shift_reg           <= DSM_MON_RESET;
            rx_channel_monitor_reg <= DSM_MON_RESET;
        end else if (rx_bit_valid && chan_hit(rx_bit, rx_channel_select_control_reg)) begin
            rx_shift_reg <= shift_in(rx_shift_reg, rx_bit.bit_val);
            if (rx_bit.bit_idx == DSM_LAST_BIT) begin
                rx_channel_monitor_reg <= shift_in(rx_shift_reg, rx_bit.bit_val);
            end
        end
    end

    // ***************************************************
    // transmit signaling registers, host written
    // ***************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < DSM_SIG_COUNT; i++) begin
                tx_sig_reg[i] <= DSM_SIG_RESET;
            end
        end else if (cpu_req.wr && is_sig_addr(cpu_req.addr, DSM_TX_SIG_BASE)) begin
            tx_sig_reg[sig_index(cpu_req.addr, DSM_TX_SIG_BASE)] <= cpu_req.wdata;
        end
    end

    // ***************************************************
    // receive signaling extraction
    // ***************************************************
    // letter advances once per frame that carried robbed bits
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sig_letter_reg <= DSM_LETTER_RESET;
            rob_seen_reg   <= 1'b0;
        end else if (rx_bit_valid) begin
            if (rx_bit.frame_start) begin
                rob_seen_reg <= 1'b0;
                if (rob_seen_reg) begin
                    sig_letter_reg <= sig_letter_reg + 2'h1;
                end
            end
            if (rx_bit.robbed) begin
                rob_seen_reg <= 1'b1;
            end
        end
    end

    // raw line bit is stored, so pass-through forcing never hides it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < DSM_SIG_COUNT; i++) begin
                rx_sig_reg[i] <= DSM_SIG_RESET;
            end
        end else if (rx_bit_valid && rx_bit.robbed && rx_chan_ok) begin
            rx_sig_reg[rx_sig_slot(sig_letter_reg, rx_bit.channel)][rx_sig_bit(rx_bit.channel)]
                <= rx_bit.bit_val;
        end
    end

    // ***************************************************
    // receive serial output, monitor taps raw line bit
    // ***************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_serial_data_out <= 1'b0;
            rx_serial_valid    <= 1'b0;
        end else begin
            rx_serial_valid <= rx_bit_valid;
            if (rx_bit_valid) begin
                if (rx_bit.robbed && signaling_pass_through_bit) begin
                    rx_serial_data_out <= 1'b1;
                end else begin
                    rx_serial_data_out <= rx_bit.bit_val;
                end
            end
        end
    end

endmodule : dsm_channel_monitor

/* File: hw/dsm_pkg.sv */
// Purpose: constants and carriers for the channel monitor block
// Assumes: 8-bit parallel register port, 24-channel T1 frames
// Notes:   offsets are register byte addresses on the parallel port
package dsm_pkg;

    // ***************************************************
    // register map
    // ***************************************************
    localparam logic [7:0] DSM_TX_SEL_OFFS     = 8'h19;
    localparam logic [7:0] DSM_TX_MON_OFFS     = 8'h1A;
    localparam logic [7:0] DSM_RX_SEL_OFFS     = 8'h1E;
    localparam logic [7:0] DSM_RX_MON_OFFS     = 8'h1F;
    localparam logic [7:0] DSM_SIG_CTRL_OFFS   = 8'h14;
    localparam logic [7:0] DSM_TX_SEL_RESET    = 8'h00;
    localparam logic [7:0] DSM_RX_SEL_RESET    = 8'h00;
    localparam logic [7:0] DSM_MON_RESET       = 8'h00;
    localparam logic [7:0] DSM_SIG_CTRL_RESET  = 8'h00;
    localparam int         DSM_SEL_MSB         = 4;
    localparam int         DSM_SIG_PASS_BIT    = 5;
    localparam logic [7:0] DSM_RX_SEL_WMASK    = 8'h9F;
    localparam logic [2:0] DSM_LAST_BIT        = 3'h7;
    localparam logic [7:0] DSM_RX_SIG_BASE     = 8'h60;
    localparam logic [7:0] DSM_TX_SIG_BASE     = 8'h70;
    localparam logic [7:0] DSM_SIG_COUNT       = 8'h0C;
    localparam logic [7:0] DSM_SIG_RESET       = 8'h00;
    localparam logic [1:0] DSM_LETTER_RESET    = 2'h0;
    localparam logic [4:0] DSM_FIRST_CH        = 5'h01;
    localparam logic [4:0] DSM_LAST_CH         = 5'h18;

    // ***************************************************
    // carriers
    // ***************************************************
    typedef struct packed {
        logic       bit_val;
        logic       frame_start;
        logic [4:0] channel;
        logic [2:0] bit_idx;
        logic       robbed;
    } dsm_bit_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dsm_cpu_req_t;

endpackage : dsm_pkg

/* File: test/dsm_chk_monitor.sv */
// Purpose: port assertions for the channel monitor
// Assumes: read data lands on the read edge
// Notes:   bound below
`timescale 1ns/1ns
module dsm_chk_monitor
    import dsm_pkg::*;
(
    input logic         clk_sys,
    input logic         sys_rst,
    input dsm_cpu_req_t cpu_req,
    input logic [7:0]   cpu_rdata,
    input logic         tx_bit_valid,
    input dsm_bit_t     tx_bit,
    input logic         rx_bit_valid,
    input dsm_bit_t     rx_bit,
    input logic         rx_serial_data_out,
    input logic         rx_serial_valid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic pass_seen;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pass_seen <= 1'b0;
        end else if (cpu_req.wr && cpu_req.addr == DSM_SIG_CTRL_OFFS) begin
            pass_seen <= cpu_req.wdata[DSM_SIG_PASS_BIT];
        end
    end
    sequence s_rd(a);
        cpu_req.rd && cpu_req.addr == a;
    endsequence
    sequence s_wr(a);
        cpu_req.wr && cpu_req.addr == a ##1 !cpu_req.wr ##1 s_rd(a);
    endsequence
    chk_ser_valid: assert property (1'b1 |=> rx_serial_valid == $past(rx_bit_valid))
        else $error("serial valid");
    chk_ser_data: assert property (rx_bit_valid && !(rx_bit.robbed && pass_seen)
        |=> rx_serial_data_out == $past(rx_bit.bit_val)) else $error("serial data");
    chk_ser_one: assert property (rx_bit_valid && rx_bit.robbed && pass_seen
        |=> rx_serial_data_out) else $error("serial one");
    chk_rdata_hold: assert property (!cpu_req.rd |=> $stable(cpu_rdata))
        else $error("rdata moved");
    chk_unmapped_rd: assert property (s_rd(8'h00) |=> cpu_rdata == 8'h00)
        else $error("unmapped read");
    chk_tx_sel: assert property (s_wr(DSM_TX_SEL_OFFS)
        |=> cpu_rdata == $past(cpu_req.wdata, 3)) else $error("tx select");
    chk_rx_sel: assert property (s_wr(DSM_RX_SEL_OFFS)
        |=> cpu_rdata == ($past(cpu_req.wdata, 3) & DSM_RX_SEL_WMASK)) else $error("rx select");
    chk_mon_stable: assert property (s_rd(DSM_TX_MON_OFFS) ##0 !tx_bit_valid
        ##1 !tx_bit_valid ##1 s_rd(DSM_TX_MON_OFFS) |=> cpu_rdata == $past(cpu_rdata, 2))
        else $error("monitor moved");
endmodule : dsm_chk_monitor
bind dsm_channel_monitor dsm_chk_monitor u_dsm_chk_monitor (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rx_serial_data_out(rx_serial_data_out), .rx_serial_valid(rx_serial_valid));

/* File: test/dsm_framer_model.sv */
// Purpose: framer datapath source for both directions
// Assumes: octets go out msb first
// Notes:   robbed bit is the octet lsb
`timescale 1ns/1ns
module dsm_framer_model
    import dsm_pkg::*;
(
    input  logic     clk_sys,
    output logic     tx_bit_valid,
    output dsm_bit_t tx_bit,
    output logic     rx_bit_valid,
    output dsm_bit_t rx_bit
);
    initial {tx_bit_valid, tx_bit, rx_bit_valid, rx_bit} = '0;
    task automatic octet(input logic [4:0] ch, input logic [7:0] tx_o, input logic [7:0] rx_o,
                         input logic rob);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            tx_bit = '{tx_o[7-i], ch == 5'h01 && i == 0, ch, i[2:0], 1'b0};
            rx_bit = '{rx_o[7-i], ch == 5'h01 && i == 0, ch, i[2:0], rob && i == 7};
            {tx_bit_valid, rx_bit_valid} = 2'h3;
        end
        @(negedge clk_sys);
        {tx_bit_valid, rx_bit_valid} = 2'h0;
        // idle lines do not keep the last value
        {tx_bit.bit_val, rx_bit.bit_val} = ~{tx_bit.bit_val, rx_bit.bit_val};
    endtask : octet
endmodule : dsm_framer_model

/* File: test/tb.sv */
// Purpose: register and datapath tests for the channel monitor
// Assumes: inputs change on the falling edge
// Notes:   serial ones are counted per octet
`timescale 1ns/1ns
module tb;
    import dsm_pkg::*;
    logic         clk_sys = 1'b0;
    logic         sys_rst = 1'b1;
    dsm_cpu_req_t cpu_req = '0;
    logic [7:0]   cpu_rdata;
    logic         tx_v, rx_v, ser_d, ser_v;
    dsm_bit_t     tx_b, rx_b;
    int           n_errors = 0, checks_done = 0, ones = 0;
    logic [7:0]   regs [5] = '{DSM_TX_SEL_OFFS, DSM_TX_MON_OFFS, DSM_RX_SEL_OFFS,
                               DSM_RX_MON_OFFS, 8'h00};
    always #2 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (ser_v === 1'b1) ones += ser_d;
    dsm_channel_monitor u_dsm_channel_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .tx_bit_valid(tx_v), .tx_bit(tx_b),
        .rx_bit_valid(rx_v), .rx_bit(rx_b), .rx_serial_data_out(ser_d), .rx_serial_valid(ser_v));
    dsm_framer_model u_dsm_framer_model (.clk_sys(clk_sys), .tx_bit_valid(tx_v),
        .tx_bit(tx_b), .rx_bit_valid(rx_v), .rx_bit(rx_b));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cpu_req = '{1'b1, 1'b0, a, d};
        @(negedge clk_sys);
        cpu_req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        cpu_req = '{1'b0, 1'b1, a, cpu_req.wdata};
        @(negedge clk_sys);
        cpu_req.rd = 1'b0;
        chk(cpu_rdata, exp);
    endtask : rd
    task automatic robbed(input logic [7:0] pass, input logic [7:0] exp);
        wr(DSM_SIG_CTRL_OFFS, pass);
        ones = 0;
        u_dsm_framer_model.octet(5'h0F, 8'h00, 8'h00, 1'b1);
        @(negedge clk_sys);
        chk(ones[7:0], exp);
    endtask : robbed
    task automatic print_verdict;
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin
        #4000;
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        wr(DSM_TX_SEL_OFFS, 8'h06);
        rd(DSM_TX_SEL_OFFS, 8'h06);
        wr(DSM_RX_SEL_OFFS, 8'hEF);
        rd(DSM_RX_SEL_OFFS, 8'h8F);
        u_dsm_framer_model.octet(5'h06, 8'hA5, 8'h00, 1'b0);
        u_dsm_framer_model.octet(5'h0F, 8'h00, 8'h3C, 1'b0);
        u_dsm_framer_model.octet(5'h07, 8'hFF, 8'hFF, 1'b0);
        rd(DSM_TX_MON_OFFS, 8'hA5);
        rd(DSM_TX_MON_OFFS, 8'hA5);
        rd(DSM_RX_MON_OFFS, 8'h3C);
        u_dsm_framer_model.octet(5'h0F, 8'h00, 8'h01, 1'b1);
        rd(8'h61, 8'h40);
        u_dsm_framer_model.octet(5'h01, 8'h00, 8'h00, 1'b0);
        u_dsm_framer_model.octet(5'h0F, 8'h00, 8'h01, 1'b1);
        wr(8'h64, 8'h00);
        rd(8'h64, 8'h40);
        rd(DSM_RX_MON_OFFS, 8'h01);
        wr(8'h7B, 8'h5A);
        rd(8'h7B, 8'h5A);
        robbed(8'h20, 8'h01);
        rd(DSM_SIG_CTRL_OFFS, 8'h20);
        robbed(8'h00, 8'h00);
        print_verdict();
    end
endmodule : tb
